//--- shared/sctir_consts.vh
/*
  Constants for the SCSI timer, response-ID and test status register bank.
  Assumes a 200 MHz system clock and an Avalon-MM slave with 32-bit data.
*/
`ifndef SCTIR_CONSTS_VH
`define SCTIR_CONSTS_VH

// Register indices (printed offsets); byte address is four times the index
`define SCTIR_IDX_TIMER_ONE   8'h49
`define SCTIR_IDX_RESP_LOW    8'h4A
`define SCTIR_IDX_RESP_HIGH   8'h4B
`define SCTIR_IDX_TEST_STAT   8'h4C
`define SCTIR_IDX_TIMER_ZERO  8'h48
`define SCTIR_IDX_IRQ_STAT    8'h50
`define SCTIR_IDX_IRQ_MASK    8'h51
`define SCTIR_IDX_CONTROL     8'h52
`define SCTIR_ADDR_W          10

// Timer one field positions
`define SCTIR_BIT_BUS_ACT     6
`define SCTIR_BIT_GEN_SCALE   5
`define SCTIR_BIT_HS_SCALE    4

// Interrupt status bits
`define SCTIR_IRQ_GEN         0
`define SCTIR_IRQ_HS          1

// Timing: base tick 100 us at 200 MHz system clock equals 20000 system clocks
`define SCTIR_BASE_TICK_NS    100000
`define SCTIR_CLK_PERIOD_NS   5
`define SCTIR_BASE_TICK_CYC   (`SCTIR_BASE_TICK_NS / `SCTIR_CLK_PERIOD_NS)
`define SCTIR_SCALE_FACTOR    16

// Reset values
`define SCTIR_TEST_RST        8'h03
`define SCTIR_ZERO8           8'h00

`endif

//--- verilog/sctir_regs.v
/*
  SCSI timer one, response-ID mask and test status register bank with a
  general-purpose timer and a handshake-to-handshake timer.
  Assumes an Avalon-MM master on sys_clk_in and SCSI bus lines that arrive
  asynchronously; each such line passes two flip-flops before use.
*/
// Local design decision: the Avalon-MM register port.
`include "sctir_consts.vh"

module sctir_regs #(
  parameter [31:0] BASE_TICK_CYC = `SCTIR_BASE_TICK_CYC
) (
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  input  wire [9:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  output reg  [1:0]  avs_response_out,
  input  wire [15:0] bus_data_in,
  input  wire        bus_busy_line_in,
  input  wire        bus_sel_in,
  input  wire        bus_req_in,
  input  wire        bus_ack_in,
  input  wire        arb_phase_in,
  input  wire        target_mode_in,
  input  wire [3:0]  chip_id_in,
  input  wire        sel_enable_in,
  input  wire        xfer_active_in,
  input  wire [4:0]  sync_offset_in,
  input  wire [3:0]  sync_offset_max_in,
  output reg         selected_out,
  output wire        arb_win_out,
  output wire        irq_out
);

  // Synchronisers for bus-side lines
  reg [21:0] sync1_r;
  reg [21:0] sync2_r;
  wire [21:0] sync_raw = {bus_data_in, bus_busy_line_in, bus_sel_in, bus_req_in,
                          bus_ack_in, arb_phase_in, target_mode_in};
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 22'h000000;
      sync2_r <= 22'h000000;
    end else begin
      sync1_r <= sync_raw;
      sync2_r <= sync1_r;
    end
  end
  wire [15:0] ids_s    = sync2_r[21:6];
  wire        busy_s   = sync2_r[5];
  wire        sel_s    = sync2_r[4];
  wire        req_s    = sync2_r[3];
  wire        ack_s    = sync2_r[2];
  wire        arb_s    = sync2_r[1];
  wire        target_s = sync2_r[0];

  // Registers
  reg [6:0]  scsi_timer_one_r;
  reg [7:0]  response_id_low_r;
  reg [7:0]  response_id_high_r;
  reg [3:0]  handshake_timer_period_r;
  reg [3:0]  selected_as_id_r;
  reg [1:0]  irq_stat_r;
  reg [1:0]  irq_mask_r;
  reg        gen_enable_r;
  reg        rd_pend_r;

  wire [3:0] general_timer_period           = scsi_timer_one_r[3:0];
  wire       handshake_timer_scale          = scsi_timer_one_r[`SCTIR_BIT_HS_SCALE];
  wire       general_timer_scale            = scsi_timer_one_r[`SCTIR_BIT_GEN_SCALE];
  wire       handshake_timer_bus_activity_en = scsi_timer_one_r[`SCTIR_BIT_BUS_ACT];

  wire [15:0] resp_mask = {response_id_high_r, response_id_low_r};

  // Highest set bit encoder
  function [4:0] sctir_top_bit;
    input [15:0] v;
    integer i;
    begin
      sctir_top_bit = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        if (v[i]) begin
          sctir_top_bit = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  // Timeout limit in ticks: 2^(code-1), times 16 when scaled
  function [15:0] sctir_limit;
    input [3:0] code;
    input       scale;
    reg   [15:0] base;
    begin
      base = 16'h0001 << (code - 4'h1);
      if (scale) begin
        sctir_limit = base << 4;
      end else begin
        sctir_limit = base;
      end
    end
  endfunction

  // Avalon decode; writes take one cycle, reads one wait state
  wire [7:0] idx   = avs_address_in[9:2];
  wire       wr_lo = avs_write_in & avs_byteenable_in[0];
  assign avs_waitrequest_out = avs_read_in & ~rd_pend_r;

  // respond to any mask ID on the bus during selection
  wire [15:0] hit_ids = ids_s & resp_mask;
  wire [4:0]  hit_enc = sctir_top_bit(hit_ids);
  wire        sel_hit = sel_s & ~busy_s & sel_enable_in & hit_enc[4];

  // arbitration on the single chip ID only
  wire [4:0] arb_top = sctir_top_bit(ids_s);
  assign arb_win_out = arb_s & arb_top[4] & (arb_top[3:0] == chip_id_in);

  // ready to be selected, without settle delay
  wire sel_ready = sel_enable_in & ~busy_s & ~selected_out;
  wire off_zero  = (sync_offset_in == 5'h00);
  wire off_max   = (sync_offset_in == {1'b0, sync_offset_max_in});

  // read-only test status with run-time values
  wire [7:0] test_stat = {selected_as_id_r, sel_ready, arb_win_out, off_zero, off_max};

  // Prescaler shared by both timers
  reg [31:0] pre_r;
  wire       tick = (pre_r == BASE_TICK_CYC - 32'h1);
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_r <= 32'h00000000;
    end else if (tick) begin
      pre_r <= 32'h00000000;
    end else begin
      pre_r <= pre_r + 32'h1;
    end
  end

  wire [15:0] gen_limit = sctir_limit(general_timer_period, general_timer_scale);
  wire [15:0] hs_limit  = sctir_limit(handshake_timer_period_r, handshake_timer_scale);

  // general timer: counts while enabled, one flag per expiry
  reg [15:0] gen_cnt_r;
  reg        gen_done_r;
  wire gen_run = gen_enable_r & (general_timer_period != 4'h0) & ~gen_done_r;
  wire gen_exp = gen_run & tick & (gen_cnt_r == gen_limit - 16'h1);
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gen_cnt_r  <= 16'h0000;
      gen_done_r <= 1'b0;
    end else if (!gen_enable_r || general_timer_period == 4'h0) begin
      gen_cnt_r  <= 16'h0000;
      gen_done_r <= 1'b0;
    end else if (gen_exp) begin
      gen_done_r <= 1'b1;
    end else if (gen_run && tick) begin
      gen_cnt_r <= gen_cnt_r + 16'h1;
    end
  end

  // handshake timer: edges of req (target) or ack (initiator)
  reg  hs_prev_r;
  wire hs_line = target_s ? req_s : ack_s;
  wire hs_edge = hs_line ^ hs_prev_r;
  // bus activity mode supervises whenever bus busy is seen
  wire hs_act  = handshake_timer_bus_activity_en ? busy_s : xfer_active_in;
  reg [15:0] hs_cnt_r;
  reg        hs_done_r;
  wire hs_run = hs_act & (handshake_timer_period_r != 4'h0) & ~hs_done_r;
  wire hs_exp = hs_run & ~hs_edge & tick & (hs_cnt_r == hs_limit - 16'h1);
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs_prev_r <= 1'b0;
      hs_cnt_r  <= 16'h0000;
      hs_done_r <= 1'b0;
    end else begin
      hs_prev_r <= hs_line;
      if (!hs_act || hs_edge || handshake_timer_period_r == 4'h0) begin
        hs_cnt_r  <= 16'h0000;
        hs_done_r <= 1'b0;
      end else if (hs_exp) begin
        hs_done_r <= 1'b1;
      end else if (hs_run && tick) begin
        hs_cnt_r <= hs_cnt_r + 16'h1;
      end
    end
  end

  // latch selected-as ID on a selection hit
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      selected_as_id_r <= 4'h0;
      selected_out     <= 1'b0;
    end else if (sel_hit && !selected_out) begin
      selected_as_id_r <= hit_enc[3:0];
      selected_out     <= 1'b1;
    end else if (!sel_s) begin
      selected_out <= 1'b0;
    end
  end

  // Register writes and sticky interrupt status; set wins over clear
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scsi_timer_one_r         <= 7'h00;
      response_id_low_r        <= `SCTIR_ZERO8;
      response_id_high_r       <= `SCTIR_ZERO8;
      handshake_timer_period_r <= 4'h0;
      irq_mask_r               <= 2'h0;
      gen_enable_r             <= 1'b0;
      irq_stat_r               <= 2'h0;
    end else begin
      if (wr_lo) begin
        case (idx)
          `SCTIR_IDX_TIMER_ONE:  scsi_timer_one_r <= avs_writedata_in[6:0];
          `SCTIR_IDX_RESP_LOW:   response_id_low_r <= avs_writedata_in[7:0];
          `SCTIR_IDX_RESP_HIGH:  response_id_high_r <= avs_writedata_in[7:0];
          `SCTIR_IDX_TIMER_ZERO: handshake_timer_period_r <= avs_writedata_in[7:4];
          `SCTIR_IDX_IRQ_MASK:   irq_mask_r <= avs_writedata_in[1:0];
          `SCTIR_IDX_CONTROL:    gen_enable_r <= avs_writedata_in[0];
          default: ;
        endcase
      end
      irq_stat_r[`SCTIR_IRQ_GEN] <= gen_exp | (irq_stat_r[`SCTIR_IRQ_GEN] &
        ~(wr_lo && idx == `SCTIR_IDX_IRQ_STAT && avs_writedata_in[`SCTIR_IRQ_GEN]));
      irq_stat_r[`SCTIR_IRQ_HS] <= hs_exp | (irq_stat_r[`SCTIR_IRQ_HS] &
        ~(wr_lo && idx == `SCTIR_IDX_IRQ_STAT && avs_writedata_in[`SCTIR_IRQ_HS]));
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // Read path: data registered, one wait state
  reg [7:0] rd_mux;
  always @* begin
    case (idx)
      `SCTIR_IDX_TIMER_ONE:  rd_mux = {1'b0, scsi_timer_one_r};
      `SCTIR_IDX_RESP_LOW:   rd_mux = response_id_low_r;
      `SCTIR_IDX_RESP_HIGH:  rd_mux = response_id_high_r;
      `SCTIR_IDX_TEST_STAT:  rd_mux = test_stat;
      `SCTIR_IDX_TIMER_ZERO: rd_mux = {handshake_timer_period_r, 4'h0};
      `SCTIR_IDX_IRQ_STAT:   rd_mux = {6'h00, irq_stat_r};
      `SCTIR_IDX_IRQ_MASK:   rd_mux = {6'h00, irq_mask_r};
      `SCTIR_IDX_CONTROL:    rd_mux = {7'h00, gen_enable_r};
      default:               rd_mux = 8'h00;
    endcase
  end

  reg is_mapped;
  always @* begin
    case (idx)
      `SCTIR_IDX_TIMER_ONE, `SCTIR_IDX_RESP_LOW, `SCTIR_IDX_RESP_HIGH,
      `SCTIR_IDX_TEST_STAT, `SCTIR_IDX_TIMER_ZERO, `SCTIR_IDX_IRQ_STAT,
      `SCTIR_IDX_IRQ_MASK, `SCTIR_IDX_CONTROL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  end

  // Read data and response stand from the answering edge
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pend_r        <= 1'b0;
      avs_readdata_out <= 32'h00000000;
      avs_response_out <= 2'h0;
    end else begin
      rd_pend_r <= avs_read_in & ~rd_pend_r;
      if (avs_read_in && !rd_pend_r) begin
        avs_readdata_out <= {24'h000000, rd_mux};
        avs_response_out <= is_mapped ? 2'h0 : 2'h2;
      end
    end
  end

endmodule

//--- tb/sctir_regs_assertions.sv
/*
  Checker for the timer, response-ID and test status register bank.
  Sees only the top module ports; attached by the bind at the foot.
*/
module sctir_regs_assertions #(
  parameter [31:0] BASE_TICK_CYC = 32'h4
) (
  input wire        sys_clk_in,
  input wire        rst_n_in,
  input wire [9:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire [1:0]  avs_response_out,
  input wire [15:0] bus_data_in,
  input wire        bus_sel_in,
  input wire        arb_phase_in,
  input wire [4:0]  sync_offset_in,
  input wire [3:0]  sync_offset_max_in,
  input wire        selected_out,
  input wire        arb_win_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Register index and map decode
  wire [7:0] idx    = avs_address_in[9:2];
  wire       mapped = idx inside {8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h50, 8'h51, 8'h52};
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Bus steps and quiet spans
  sequence s_rd_start; avs_read_in && avs_waitrequest_out; endsequence
  sequence s_rd_done; avs_read_in && !avs_waitrequest_out; endsequence
  sequence s_no_sel; (!bus_sel_in) [*4]; endsequence
  sequence s_no_ids; (bus_data_in == 16'h0000) [*4]; endsequence
  sequence s_no_arb; (!arb_phase_in) [*4]; endsequence
  // Bus handshake timing
  property p_rd_wait; s_rd_start |=> !avs_waitrequest_out; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read not answered in one cycle");
  property p_wr_nowait; avs_write_in |-> !avs_waitrequest_out; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  // Read answers
  property p_unmapped;
    s_rd_done ##0 !mapped |-> avs_response_out == 2'h2 && avs_readdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answer wrong");
  property p_mapped;
    s_rd_done ##0 mapped |-> avs_response_out == 2'h0 && avs_readdata_out[31:8] == 24'h0;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read answer wrong");
  property p_offset;
    s_rd_done ##0 idx == 8'h4C |-> avs_readdata_out[1:0] == {$past(sync_offset_in) == 5'h00,
      $past(sync_offset_in) == {1'b0, $past(sync_offset_max_in)}};
  endproperty
  a_offset: assert property (p_offset) else $error("offset bits wrong");
  // Selection and arbitration outputs
  property p_no_sel; s_no_sel |-> !selected_out; endproperty
  a_no_sel: assert property (p_no_sel) else $error("selected without select");
  property p_no_ids; s_no_ids |-> !arb_win_out; endproperty
  a_no_ids: assert property (p_no_ids) else $error("win with no ID on bus");
  property p_no_arb; s_no_arb |-> !arb_win_out; endproperty
  a_no_arb: assert property (p_no_arb) else $error("win outside arbitration");
endmodule

bind sctir_regs sctir_regs_assertions #(.BASE_TICK_CYC(BASE_TICK_CYC)) chk_u (.*);

//--- tb/sctir_bus_agent.sv
/*
  SCSI bus agent: drives ID, busy, select, arbitration and handshake lines.
  Assumes bench calls; released lines read 0, as terminated idle lines do.
*/
module sctir_bus_agent (
  input  wire        clk_in,
  output reg  [15:0] bus_data_out,
  output reg         busy_out,
  output reg         sel_out,
  output reg         arb_out,
  output reg         req_out,
  output reg         ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    {bus_data_out, busy_out, sel_out, arb_out, req_out, ack_out} = 21'h0;
  end
  // One bus phase placed just after an edge
  task automatic drive(input [15:0] ids, input bsy, input sel, input arb);
    @(posedge clk_in);
    bus_data_out <= ids;
    busy_out <= bsy;
    sel_out <= sel;
    arb_out <= arb;
  endtask
  // Handshake edges every two clocks
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (2) @(posedge clk_in);
      req_out <= ~req_out;
      ack_out <= ~ack_out;
    end
  endtask
endmodule

//--- tb/tb_top.sv
/*
  Self-checking bench for the register bank, with a bus agent on the far side.
  Assumes a 200 MHz clock and a shortened timer tick of four clocks.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, rd, wr, sel_en;
  logic [9:0]  addr;
  logic [31:0] wdata;
  logic [3:0]  chip_id, offs_max;
  logic [4:0]  offs;
  logic [7:0]  d;
  wire  [31:0] rdata;
  wire  [1:0]  resp;
  wire  [15:0] ids;
  wire         wq, selected, arb_win, irq, bsy, sel, arb, req, ack;
  int          n_mismatch, n_tests;
  // Design and bus agent
  sctir_regs #(.BASE_TICK_CYC(32'h4)) dut_u (.sys_clk_in(clk), .rst_n_in(rst_n),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
    .avs_response_out(resp), .bus_data_in(ids), .bus_busy_line_in(bsy), .bus_sel_in(sel),
    .bus_req_in(req), .bus_ack_in(ack), .arb_phase_in(arb), .target_mode_in(1'b0),
    .chip_id_in(chip_id), .sel_enable_in(sel_en), .xfer_active_in(1'b0),
    .sync_offset_in(offs), .sync_offset_max_in(offs_max), .selected_out(selected),
    .arb_win_out(arb_win), .irq_out(irq));
  sctir_bus_agent agent (.clk_in(clk), .bus_data_out(ids), .busy_out(bsy), .sel_out(sel),
    .arb_out(arb), .req_out(req), .ack_out(ack));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input [31:0] seen, input [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Avalon write and read, held until waitrequest is seen low
  task automatic wbus(input [7:0] i, input [7:0] v);
    @(posedge clk);
    addr <= {i, 2'b00};
    wdata <= {24'h0, v};
    wr <= 1'b1;
    do @(posedge clk); while (wq !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic rbus(input [7:0] i, output [7:0] v);
    @(posedge clk);
    addr <= {i, 2'b00};
    rd <= 1'b1;
    do @(posedge clk); while (wq !== 1'b0);
    v = rdata[7:0];
    rd <= 1'b0;
  endtask
  task automatic rchk(input [7:0] i, input [7:0] exp, input [7:0] m, input string nm);
    rbus(i, d);
    chk({24'h0, d & m}, {24'h0, exp}, nm);
  endtask
  task automatic bus(input [15:0] v, input b, input s, input a);
    agent.drive(v, b, s, a);
    repeat (6) @(posedge clk);
  endtask
  task automatic t_reset;
    rchk(8'h49, 8'h00, 8'h7F, "timer_one");
    rchk(8'h4C, 8'h03, 8'hFB, "test_status");
    wbus(8'h4C, 8'hF4);
    rchk(8'h4C, 8'h03, 8'hFB, "test_ro");
    rbus(8'h4D, d);
    chk({22'h0, resp, d}, 32'h200, "unmapped");
    wbus(8'h4A, 8'hA5);
    wbus(8'h4B, 8'h5A);
    rchk(8'h4A, 8'hA5, 8'hFF, "resp_low");
    rchk(8'h4B, 8'h5A, 8'hFF, "resp_high");
  endtask
  task automatic t_select;
    sel_en <= 1'b1;
    wbus(8'h4A, 8'h20);
    wbus(8'h4B, 8'h10);
    rchk(8'h4C, 8'h08, 8'h08, "sel_ready");
    bus(16'h1000, 1'b0, 1'b1, 1'b0);
    chk(selected, 1, "selected_12");
    rchk(8'h4C, 8'hC0, 8'hF8, "sel_as_12");
    bus(16'h0, 1'b0, 1'b0, 1'b0);
    bus(16'h0020, 1'b0, 1'b1, 1'b0);
    rchk(8'h4C, 8'h50, 8'hF0, "sel_as_5");
    bus(16'h0, 1'b0, 1'b0, 1'b0);
    bus(16'h0200, 1'b0, 1'b1, 1'b0);
    chk(selected, 0, "not_mine");
    bus(16'h0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_arb;
    wbus(8'h4A, 8'h80);
    bus(16'h000A, 1'b1, 1'b0, 1'b1);
    rchk(8'h4C, 8'h04, 8'h04, "arb_win");
    bus(16'h0088, 1'b1, 1'b0, 1'b1);
    chk(arb_win, 0, "arb_lose");
    bus(16'h0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_offset;
    logic [10:0] tab [4] = '{11'h00A, 11'h265, 11'h100, 11'h003};
    foreach (tab[k]) begin
      @(posedge clk);
      {offs, offs_max} <= tab[k][10:2];
      rchk(8'h4C, {6'h0, tab[k][1:0]}, 8'h03, "offset");
    end
  endtask
  task automatic gen(input [7:0] code, input int early, input int late);
    wbus(8'h49, 8'h00);
    wbus(8'h49, code);
    wbus(8'h50, 8'h01);
    wbus(8'h52, 8'h01);
    repeat (early) @(posedge clk);
    rchk(8'h50, 8'h00, 8'h01, "gen_early");
    repeat (late) @(posedge clk);
    rchk(8'h50, 8'h01, 8'h01, "gen_late");
    wbus(8'h52, 8'h00);
  endtask
  task automatic t_gen;
    wbus(8'h51, 8'h00);
    gen(8'h03, 8, 24);
    gen(8'h22, 100, 50);
    repeat (2) @(posedge clk);
    chk(irq, 0, "irq_masked");
    wbus(8'h51, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1, "irq_set");
    wbus(8'h50, 8'h01);
    wbus(8'h51, 8'h00);
    repeat (20) @(posedge clk);
    rchk(8'h50, 8'h00, 8'h01, "gen_cleared");
    chk(irq, 0, "irq_clear");
  endtask
  task automatic t_hs;
    wbus(8'h48, 8'h20);
    wbus(8'h49, 8'h40);
    wbus(8'h50, 8'h03);
    agent.drive(16'h0, 1'b1, 1'b0, 1'b0);
    fork
      agent.toggle(20);
      rchk(8'h50, 8'h00, 8'h02, "hs_active");
    join
    repeat (40) @(posedge clk);
    rchk(8'h50, 8'h02, 8'h02, "hs_timeout");
    wbus(8'h49, 8'h00);
    wbus(8'h50, 8'h03);
    repeat (40) @(posedge clk);
    rchk(8'h50, 8'h00, 8'h02, "hs_off");
    bus(16'h0, 1'b0, 1'b0, 1'b0);
  endtask
  // Reset, then the scenarios
  initial begin
    {rst_n, rd, wr, addr, wdata, offs, offs_max} = 54'h0;
    chip_id = 4'h3;
    sel_en = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_select;
    t_arb;
    t_offset;
    t_gen;
    t_hs;
    results;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results;
  end
endmodule
